/* hw/rpw_flags.sv */
// sticky flags, set by hardware, cleared by writing one; set wins
`timescale 1ns/1ps
module rpw_flags #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// set and clear vectors
	input  wire logic [WIDTH-1:0] setFlags,
	input  wire logic [WIDTH-1:0] clrFlags,
	// flags
	output wire logic [WIDTH-1:0] flags
);

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} rpw_flags_t;

	rpw_flags_t s;
	rpw_flags_t next_s;

	always_comb
	begin
		next_s.flags = (s.flags & ~clrFlags) | setFlags;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign flags = s.flags;

endmodule

/* hw/rpw_pkg.sv */
// constants, link state codes and register map of the root port wake block
package rpw_pkg;

	// ****************************************
	// bus and register map
	// ****************************************
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] PORT_SC_ADDR  = 8'h00;
	localparam logic [7:0] CTRL_STS_ADDR = 8'h04;
	localparam logic [7:0] PM_CS_ADDR    = 8'h08;
	localparam logic [7:0] INT_STS_ADDR  = 8'h0c;
	localparam logic [7:0] INT_MASK_ADDR = 8'h10;

	// port status and control fields
	localparam int LS_LSB        = 0;
	localparam int CONNECT_BIT   = 4;
	localparam int ENABLE_BIT    = 5;
	localparam int OC_BIT        = 6;
	localparam int POWER_BIT     = 7;
	localparam int USB3_BIT      = 8;
	localparam int CHG_LSB       = 9;
	localparam int WAKE_DISC_BIT = 12;
	localparam int WAKE_CONN_BIT = 13;
	localparam int WAKE_OC_BIT   = 14;
	localparam int ACTIVE_BIT    = 15;
	localparam int LWS_BIT       = 16;

	// power management fields
	localparam int WAKE_EN_BIT  = 0;
	localparam int WAKE_STS_BIT = 1;
	localparam int FULL_ON_BIT  = 2;

	// interrupt status bits
	localparam int INT_W          = 5;
	localparam int INT_RESUME     = 0;
	localparam int INT_DISCONNECT = 1;
	localparam int INT_CONNECT    = 2;
	localparam int INT_OVERCUR    = 3;
	localparam int INT_PORT_EVT   = 4;

	// change flags: link, connect, over-current
	localparam int CHG_W     = 3;
	localparam int CHG_LINK  = 0;
	localparam int CHG_CONN  = 1;
	localparam int CHG_OC    = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic             POWER_RST    = 1'b1;
	localparam logic             USB3_RST     = 1'b0;
	localparam logic             FULL_ON_RST  = 1'b1;
	localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS      = 100;
	localparam int RESUME_REFLECT_NS  = 1000000;
	localparam int RESUME_REFLECT_CYC = RESUME_REFLECT_NS / CLK_PERIOD_NS;

	// ****************************************
	// link state codes
	// ****************************************
	typedef enum logic [3:0] {
		LS_U0         = 4'h0,
		LS_U1         = 4'h1,
		LS_U2         = 4'h2,
		LS_U3         = 4'h3,
		LS_DISABLED   = 4'h4,
		LS_RXDETECT   = 4'h5,
		LS_ERROR      = 4'h6,
		LS_POLLING    = 4'h7,
		LS_RECOVERY   = 4'h8,
		LS_RESET      = 4'h9,
		LS_COMPLIANCE = 4'ha,
		LS_LOOPBACK   = 4'hb,
		LS_RESUME     = 4'hf
	} rpw_link_t;

	localparam rpw_link_t LS_RST = LS_RXDETECT;

	// states in which a disconnect can be seen
	function automatic logic rpw_disc_capable(input rpw_link_t ls, input logic usb3);
		logic enabledLs;
		enabledLs = (ls == LS_U0) || (ls == LS_U1) || (ls == LS_U2);
		if (usb3)
			return enabledLs || (ls == LS_LOOPBACK) || (ls == LS_COMPLIANCE) ||
				(ls == LS_ERROR) || (ls == LS_POLLING) || (ls == LS_RESET);
		else
			return enabledLs || (ls == LS_DISABLED) || (ls == LS_POLLING);
	endfunction

endpackage

/* hw/rpw_root_port_wake.sv */
// root hub port wake-up event logic with its apb register file
// What this block does
// - usb2 resume reflected downstream within 1 ms, held
// - usb3 wake signal in suspend: resume, link change
// - active means enabled and link state below three
// - resume in suspend: resume, connected, enabled, change
// - disconnect: rxdetect, cleared flags, change detect
// - connect: usb3 active enabled, usb2 polling disabled
// - over-current: disabled, flag set, change detect
// - disconnect seen only in the listed port states
// - over-current seen whenever the port is powered
// - per-port wake enables gate wake for these events
// - resume always wakes, gated only by wake enable
// - change term rising in fully-on raises event
// - resume is 15, suspended 3, active 0
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module rpw_root_port_wake #(
	parameter int RESUME_REFLECT_CYC = rpw_pkg::RESUME_REFLECT_CYC
) (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [rpw_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output wire logic [31:0]               prdata,
	output wire logic                      pready,
	output wire logic                      pslverr,
	// port pins
	input  wire logic                      attachDet,
	input  wire logic                      resumeDet,
	input  wire logic                      overcurrentDet,
	// system side
	output wire logic                      resumeDrive,
	output wire logic                      wakeRequest,
	output wire logic                      portChangeEvent,
	output wire logic                      irq
);

	import rpw_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		rpw_link_t        linkState;
		logic             connect;
		logic             enabled;
		logic             overcurrent;
		logic             portPower;
		logic             usb3;
		logic             wakeDisc;
		logic             wakeConn;
		logic             wakeOc;
		logic             wakeEnable;
		logic             fullyOn;
		logic [INT_W-1:0] intMask;
		logic [2:0]       pinPrev;
		logic             changeGenPrev;
		logic             changeEvent;
		logic [31:0]      rdata;
		logic             slvErr;
	} rpw_state_t;

	rpw_state_t s;
	rpw_state_t next_s;

	logic [2:0]       pinSync;
	logic [CHG_W-1:0] chgFlags, chgSet, chgClr;
	logic [INT_W-1:0] intStatus, intSet, intClr;
	logic             portChgFlag, portChgSet, portChgClr, wakeStatus, wakeSet, wakeClr;
	logic             attachRise, attachFall, resumeRise, ocRise, ocEvt, discEvt;
	logic             connEvt, resEvt, anyEvt, changeGen, portActive;
	logic             wrAccess, wrPort, wrPm, setupPhase;

	// ****************************************
	// pin synchronisers and status flags
	// ****************************************
	rpw_sync #(.WIDTH(3)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  ({attachDet, resumeDet, overcurrentDet}),
		.syncOut  (pinSync)
	);
	rpw_flags #(.WIDTH(CHG_W)) u_chg (
		.core_clk (core_clk),
		.rst      (rst),
		.setFlags (chgSet),
		.clrFlags (chgClr),
		.flags    (chgFlags)
	);
	rpw_flags #(.WIDTH(1)) u_portchg (
		.core_clk (core_clk),
		.rst      (rst),
		.setFlags (portChgSet),
		.clrFlags (portChgClr),
		.flags    (portChgFlag)
	);
	rpw_flags #(.WIDTH(1)) u_wake (
		.core_clk (core_clk),
		.rst      (rst),
		.setFlags (wakeSet),
		.clrFlags (wakeClr),
		.flags    (wakeStatus)
	);
	rpw_flags #(.WIDTH(INT_W)) u_int (
		.core_clk (core_clk),
		.rst      (rst),
		.setFlags (intSet),
		.clrFlags (intClr),
		.flags    (intStatus)
	);

	// ****************************************
	// port events, highest priority first, and bus decode
	// ****************************************
	always_comb
	begin
		attachRise = pinSync[2] & ~s.pinPrev[2];
		attachFall = ~pinSync[2] & s.pinPrev[2];
		resumeRise = pinSync[1] & ~s.pinPrev[1];
		ocRise     = pinSync[0] & ~s.pinPrev[0];
		ocEvt      = ocRise & s.portPower;
		discEvt    = attachFall & s.connect & ~ocEvt &
			rpw_disc_capable(s.linkState, s.usb3);
		connEvt    = attachRise & ~s.connect & s.portPower & ~ocEvt;
		resEvt     = resumeRise & (s.linkState == LS_U3) & ~ocEvt & ~discEvt;
		anyEvt     = ocEvt | discEvt | connEvt | resEvt;
	end

	assign setupPhase = psel & ~penable;
	assign wrAccess   = psel & penable & pwrite;
	assign wrPort     = wrAccess && (paddr == PORT_SC_ADDR);
	assign wrPm       = wrAccess && (paddr == PM_CS_ADDR);
	assign portActive = s.enabled && (s.linkState < LS_U3);
	assign changeGen  = |chgFlags;

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_s  = s;
		chgSet[CHG_LINK] = resEvt;
		chgSet[CHG_CONN] = discEvt | connEvt | ocEvt;
		chgSet[CHG_OC]   = ocEvt;
		next_s.pinPrev   = pinSync;
		// software link state writes, overridden by port events
		if (wrPort && pwdata[LWS_BIT])
		begin
			unique case (rpw_link_t'(pwdata[LS_LSB+:4]))
				LS_U0:
					if (s.linkState == LS_RESUME)
					begin
						next_s.linkState = LS_U0;
						chgSet[CHG_LINK] = 1'b1;
					end
				LS_U3:
					if (portActive)
						next_s.linkState = LS_U3;
				LS_RESUME:
					if (!s.usb3 && s.linkState == LS_U3)
						next_s.linkState = LS_RESUME;
				default:
					next_s.linkState = s.linkState;
			endcase
		end
		if (ocEvt)
		begin
			next_s.linkState   = LS_DISABLED;
			next_s.connect     = 1'b0;
			next_s.enabled     = 1'b0;
			next_s.overcurrent = 1'b1;
		end
		else if (discEvt)
		begin
			next_s.linkState   = LS_RXDETECT;
			next_s.connect     = 1'b0;
			next_s.enabled     = 1'b0;
			next_s.overcurrent = 1'b0;
		end
		else if (connEvt)
		begin
			next_s.linkState   = s.usb3 ? LS_U0 : LS_POLLING;
			next_s.connect     = 1'b1;
			next_s.enabled     = s.usb3;
			next_s.overcurrent = 1'b0;
		end
		else if (resEvt)
		begin
			next_s.linkState   = LS_RESUME;
			next_s.connect     = 1'b1;
			next_s.enabled     = 1'b1;
			next_s.overcurrent = 1'b0;
		end
		if (wrPort)
		begin
			next_s.portPower = pwdata[POWER_BIT];
			next_s.usb3      = pwdata[USB3_BIT];
			next_s.wakeDisc  = pwdata[WAKE_DISC_BIT];
			next_s.wakeConn  = pwdata[WAKE_CONN_BIT];
			next_s.wakeOc    = pwdata[WAKE_OC_BIT];
		end
		if (wrPm)
		begin
			next_s.wakeEnable = pwdata[WAKE_EN_BIT];
			next_s.fullyOn    = pwdata[FULL_ON_BIT];
		end
		if (wrAccess && paddr == INT_MASK_ADDR)
			next_s.intMask = pwdata[INT_W-1:0];
		// status change event on a rising change term in fully-on
		next_s.changeGenPrev = changeGen;
		next_s.changeEvent   = s.fullyOn & changeGen & ~s.changeGenPrev;
		// read data captured in the setup cycle
		next_s.rdata  = '0;
		next_s.slvErr = 1'b0;
		if (setupPhase)
		begin
			unique case (paddr)
				PORT_SC_ADDR:
				begin
					next_s.rdata[LS_LSB+:4]           = s.linkState;
					next_s.rdata[CONNECT_BIT]         = s.connect;
					next_s.rdata[ENABLE_BIT]          = s.enabled;
					next_s.rdata[OC_BIT]              = s.overcurrent;
					next_s.rdata[POWER_BIT]           = s.portPower;
					next_s.rdata[USB3_BIT]            = s.usb3;
					next_s.rdata[CHG_LSB+:CHG_W]      = chgFlags;
					next_s.rdata[WAKE_DISC_BIT]       = s.wakeDisc;
					next_s.rdata[WAKE_CONN_BIT]       = s.wakeConn;
					next_s.rdata[WAKE_OC_BIT]         = s.wakeOc;
					next_s.rdata[ACTIVE_BIT]          = portActive;
				end
				CTRL_STS_ADDR:
					next_s.rdata[0] = portChgFlag;
				PM_CS_ADDR:
				begin
					next_s.rdata[WAKE_EN_BIT]  = s.wakeEnable;
					next_s.rdata[WAKE_STS_BIT] = wakeStatus;
					next_s.rdata[FULL_ON_BIT]  = s.fullyOn;
				end
				INT_STS_ADDR:
					next_s.rdata[INT_W-1:0] = intStatus;
				INT_MASK_ADDR:
					next_s.rdata[INT_W-1:0] = s.intMask;
				default:
					next_s.slvErr = 1'b1;
			endcase
		end
	end

	// flag set and clear terms
	always_comb
	begin
		chgClr     = wrPort ? pwdata[CHG_LSB+:CHG_W] : '0;
		portChgSet = anyEvt;
		portChgClr = wrAccess && (paddr == CTRL_STS_ADDR) && pwdata[0];
		wakeSet = resEvt | (discEvt & s.wakeDisc) | (connEvt & s.wakeConn) |
			(ocEvt & s.wakeOc);
		wakeClr = wrPm & pwdata[WAKE_STS_BIT];
		intSet  = {s.changeEvent, ocEvt, connEvt, discEvt, resEvt};
		intClr  = (wrAccess && paddr == INT_STS_ADDR) ? pwdata[INT_W-1:0] : '0;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s             <= '0;
			s.linkState   <= LS_RST;
			s.portPower   <= POWER_RST;
			s.usb3        <= USB3_RST;
			s.fullyOn     <= FULL_ON_RST;
			s.intMask     <= INT_MASK_RST;
		end
		else
			s <= next_s;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata          = s.rdata;
	assign pslverr         = s.slvErr & psel & penable;
	assign pready          = 1'b1;
	assign resumeDrive     = ~s.usb3 & (s.linkState == LS_RESUME);
	assign wakeRequest     = wakeStatus & s.wakeEnable;
	assign portChangeEvent = s.changeEvent;
	assign irq             = |(intStatus & s.intMask);

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	logic [31:0] reflectWait;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			reflectWait <= '0;
		else if ((resEvt && !s.usb3) || (reflectWait != 32'h0 && !resumeDrive))
			reflectWait <= reflectWait + 32'h1;
		else
			reflectWait <= '0;
	end

	reflect_time_a: assert property (reflectWait < 32'(RESUME_REFLECT_CYC))
		else $error("resume not reflected in time");
	usb3_resume_a: assert property (resEvt && s.usb3 |=> s.linkState == LS_RESUME
		&& chgFlags[CHG_LINK]) else $error("usb3 wake did not enter resume");
	resume_entry_a: assert property (resEvt |=> s.linkState == 4'hf && s.connect
		&& s.enabled && !s.overcurrent && portChgFlag) else $error("bad resume entry");
	disc_entry_a: assert property (discEvt |=> s.linkState == LS_RXDETECT
		&& !s.connect && !s.enabled && !s.overcurrent && portChgFlag)
		else $error("bad disconnect entry");
	conn_entry_a: assert property (connEvt |=> s.connect && portChgFlag
		&& (s.usb3 ? (s.linkState == LS_U0 && s.enabled)
		: (s.linkState == LS_POLLING && !s.enabled))) else $error("bad connect entry");
	oc_entry_a: assert property (ocEvt |=> s.linkState == LS_DISABLED
		&& s.overcurrent && !s.connect && !s.enabled && portChgFlag)
		else $error("bad over-current entry");
	wake_gate_a: assert property (discEvt && !s.wakeDisc && !wakeStatus
		&& !connEvt |=> !wakeStatus) else $error("ungated disconnect wake");
	resume_wake_a: assert property (resEvt && s.wakeEnable && !wrPm |=> wakeRequest)
		else $error("resume did not request wake");
	change_event_a: assert property (s.fullyOn && changeGen && !s.changeGenPrev
		|=> portChangeEvent ##1 !portChangeEvent) else $error("missing change event");
	disabled_resume_a: assert property (resumeRise && s.linkState == LS_DISABLED
		&& !anyEvt && !wrPort && !wrPm |=> $stable(s.linkState) && $stable(wakeStatus))
		else $error("resume acted on disabled port");

endmodule

/* hw/rpw_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rpw_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// pins and synchronised levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output wire logic [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] ff1;
		logic [WIDTH-1:0] ff2;
	} rpw_sync_t;

	rpw_sync_t s;
	rpw_sync_t next_s;

	always_comb
	begin
		next_s.ff1 = asyncIn;
		next_s.ff2 = s.ff1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign syncOut = s.ff2;

endmodule

/* verification/rpw_dev_model.sv */
// attached device model driving the root port pins
`timescale 1ns/1ps
module rpw_dev_model (
	// clock
	input  wire logic core_clk,
	// port pins
	output logic      attachDet,
	output wire logic resumeDet,
	output wire logic overcurrentDet
);
	int resCnt = 0;
	int ocCnt  = 0;

	initial attachDet = 1'b0;

	// ****************************************
	// wake and over-current pulses
	// ****************************************
	// held several cycles so the pin synchroniser cannot miss them
	assign resumeDet      = resCnt > 0;
	assign overcurrentDet = ocCnt > 0;

	always @(posedge core_clk)
	begin
		if (resCnt > 0)
			resCnt <= resCnt - 1;
		if (ocCnt > 0)
			ocCnt <= ocCnt - 1;
	end

	// ****************************************
	// commands, called just after a rising edge
	// ****************************************
	// a new attach while attached first detaches, so a fresh rise is seen
	task automatic plug(input logic lvl);
		if (lvl && attachDet)
		begin
			attachDet <= 1'b0;
			repeat (6) @(posedge core_clk);
		end
		attachDet <= lvl;
	endtask

	task automatic wake();
		resCnt <= 6;
	endtask

	task automatic overcur();
		ocCnt <= 6;
	endtask
endmodule

/* verification/tb.sv */
// self-checking testbench of the root port wake block
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		nTests++; \
		if ((g) !== (e)) \
		begin \
			errorCnt++; \
			$display("mismatch at %0t: got %h expected %h", $time, (g), (e)); \
		end \
	end
module tb;
	import rpw_pkg::*;

	typedef struct packed {
		logic [1:0] ev;
		logic       usb3;
		logic [2:0] we;
		logic       fullOn;
		logic [6:0] fld;
		logic       wake;
		logic       evt;
	} rpw_row_t;

	// ev: 0 connect, 1 disconnect, 2 over-current; fld: {oc, en, connect, link}
	localparam rpw_row_t ROWS [7] = '{
		{2'd0, 1'b0, 3'b010, 1'b1, 7'h17, 1'b1, 1'b1},
		{2'd1, 1'b0, 3'b000, 1'b1, 7'h05, 1'b0, 1'b1},
		{2'd0, 1'b1, 3'b000, 1'b1, 7'h30, 1'b0, 1'b1},
		{2'd2, 1'b1, 3'b100, 1'b1, 7'h44, 1'b1, 1'b1},
		{2'd0, 1'b1, 3'b010, 1'b1, 7'h30, 1'b1, 1'b1},
		{2'd1, 1'b1, 3'b001, 1'b1, 7'h05, 1'b1, 1'b1},
		{2'd2, 1'b0, 3'b000, 1'b0, 7'h44, 1'b0, 1'b0}
	};

	logic              core_clk;
	logic              rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	wire logic [31:0]  prdata;
	wire logic         pready;
	wire logic         pslverr;
	wire logic         attachDet;
	wire logic         resumeDet;
	wire logic         overcurrentDet;
	wire logic         resumeDrive;
	wire logic         wakeRequest;
	wire logic         portChangeEvent;
	wire logic         irq;
	logic [31:0]       rd;
	logic              err;
	logic              seen;
	int                errorCnt = 0;
	int                nTests   = 0;
	int                cyc      = 0;

	rpw_root_port_wake #(.RESUME_REFLECT_CYC(16)) rpw_root_port_wake_inst (
		.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.attachDet(attachDet), .resumeDet(resumeDet), .overcurrentDet(overcurrentDet),
		.resumeDrive(resumeDrive), .wakeRequest(wakeRequest),
		.portChangeEvent(portChangeEvent), .irq(irq)
	);

	rpw_dev_model rpw_dev_model_inst (
		.core_clk(core_clk), .attachDet(attachDet), .resumeDet(resumeDet),
		.overcurrentDet(overcurrentDet)
	);

	// ****************************************
	// clock, timeout and closing report
	// ****************************************
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic conclude();
		if (errorCnt == 0 && nTests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errorCnt++;
			conclude();
		end
	end

	// ****************************************
	// bus and helper tasks
	// ****************************************
	// one apb transfer followed by an idle cycle; read data taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	function automatic logic [31:0] pw(input logic u, input logic [2:0] we);
		return {17'h0, we, 3'b000, u, 1'b1, 7'h00};
	endfunction

	// clears change flags, change detect, wake status and interrupt status
	task automatic prep(input logic u, input logic [2:0] we, input logic fo);
		apb(1'b1, PORT_SC_ADDR, pw(u, we) | 32'h0e00);
		apb(1'b1, CTRL_STS_ADDR, 32'h1);
		apb(1'b1, PM_CS_ADDR, {29'h0, fo, 2'b11});
		apb(1'b1, INT_STS_ADDR, 32'h1f);
	endtask

	task automatic waitEvt();
		seen = 1'b0;
		for (int i = 0; i < 20 && !seen; i++)
		begin
			@(posedge core_clk);
			seen = (portChangeEvent === 1'b1);
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 7; i++)
		begin
			prep(ROWS[i].usb3, ROWS[i].we, ROWS[i].fullOn);
			`CHK(wakeRequest, 1'b0)
			case (ROWS[i].ev)
				2'd0: rpw_dev_model_inst.plug(1'b1);
				2'd1: rpw_dev_model_inst.plug(1'b0);
				default: rpw_dev_model_inst.overcur();
			endcase
			waitEvt();
			`CHK(seen, ROWS[i].evt)
			apb(1'b0, PORT_SC_ADDR, 32'h0);
			`CHK(rd[6:0], ROWS[i].fld)
			`CHK(wakeRequest, ROWS[i].wake)
			apb(1'b0, CTRL_STS_ADDR, 32'h0);
			`CHK(rd[0], 1'b1)
			`CHK(irq, 1'b0)
		end
		// wake signal on a disabled port
		prep(1'b0, 3'b000, 1'b1);
		rpw_dev_model_inst.wake();
		waitEvt();
		`CHK(seen, 1'b0)
		apb(1'b0, PORT_SC_ADDR, 32'h0);
		`CHK(rd[6:0], 7'h44)
		`CHK(wakeRequest, 1'b0)
		apb(1'b0, CTRL_STS_ADDR, 32'h0);
		`CHK(rd[0], 1'b0)
		// suspend and device wake, usb3 then usb2
		prep(1'b1, 3'b000, 1'b1);
		rpw_dev_model_inst.plug(1'b1);
		waitEvt();
		for (int u = 1; u >= 0; u--)
		begin
			prep(u[0], 3'b000, 1'b1);
			apb(1'b0, PORT_SC_ADDR, 32'h0);
			`CHK(rd[15], 1'b1)
			apb(1'b1, PORT_SC_ADDR, pw(u[0], 3'b000) | 32'h10003);
			prep(u[0], 3'b000, 1'b1);
			apb(1'b0, PORT_SC_ADDR, 32'h0);
			`CHK({rd[15], rd[3:0]}, 5'h03)
			rpw_dev_model_inst.wake();
			waitEvt();
			`CHK(seen, 1'b1)
			apb(1'b0, PORT_SC_ADDR, 32'h0);
			`CHK(rd[9:0], {1'b1, u[0], 8'hbf})
			`CHK(wakeRequest, 1'b1)
			`CHK(resumeDrive, ~u[0])
			repeat (8) @(posedge core_clk);
			`CHK(resumeDrive, ~u[0])
			apb(1'b1, PORT_SC_ADDR, pw(u[0], 3'b000) | 32'h10000);
			apb(1'b0, PORT_SC_ADDR, 32'h0);
			`CHK({resumeDrive, rd[3:0]}, 5'h00)
		end
		// wake status kept while the enable is off
		apb(1'b1, PM_CS_ADDR, 32'h4);
		`CHK(wakeRequest, 1'b0)
		apb(1'b0, PM_CS_ADDR, 32'h0);
		`CHK(rd[2:0], 3'h6)
		// interrupt mask and clear, unmapped access
		apb(1'b1, INT_MASK_ADDR, 32'h1);
		`CHK(irq, 1'b1)
		apb(1'b1, INT_STS_ADDR, 32'h1);
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h14, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		apb(1'b0, INT_MASK_ADDR, 32'h0);
		`CHK(rd[4:0], 5'h01)
		// reset in mid-run
		rpw_dev_model_inst.plug(1'b0);
		repeat (20) @(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		@(posedge core_clk);
		`CHK({wakeRequest, irq, portChangeEvent, resumeDrive, pslverr, prdata}, 37'h0)
		rst <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, PORT_SC_ADDR, 32'h0);
		`CHK(rd, 32'h00000085)
		apb(1'b0, PM_CS_ADDR, 32'h0);
		`CHK(rd, 32'h00000004)
		apb(1'b0, CTRL_STS_ADDR, 32'h0);
		`CHK(rd, 32'h00000000)
		conclude();
	end
endmodule
